//--- src/cmc_control_top.sv
// Mode, self-trim and multi-device sync control with an AXI4-Lite register port.
// Assumes all pins are synchronous to aclk; one write and one read in flight.
`timescale 1ns/10ps
module cmc_control_top
#(
  parameter int WAIT_LONG_CYC  = cmc_pkg::us_to_cycles(cmc_pkg::WAIT_LONG_US),
  parameter int WAIT_SHORT_CYC = cmc_pkg::us_to_cycles(cmc_pkg::WAIT_SHORT_US),
  parameter int RUN_CYC        = cmc_pkg::us_to_cycles(cmc_pkg::CAL_RUN_US)
)
(
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [cmc_pkg::ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic [2:0]                    s_axi_awprot,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  input  wire logic [cmc_pkg::DATA_W-1:0]    s_axi_wdata,
  input  wire logic [cmc_pkg::DATA_W/8-1:0]  s_axi_wstrb,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  output logic [1:0]                         s_axi_bresp,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  input  wire logic [cmc_pkg::ADDR_W-1:0]    s_axi_araddr,
  input  wire logic [2:0]                    s_axi_arprot,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output logic [cmc_pkg::DATA_W-1:0]         s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  input  wire logic                          serial_control_enable_n,
  input  wire logic                          interleave_select,
  input  wire logic                          power_on_trim_wait_select,
  input  wire logic                          selftrim_request,
  input  wire logic                          sync_enable,
  input  wire logic                          sync_slave,
  input  wire logic                          ref_clk_in,
  output logic                               sync_ref_clock_out_a,
  output logic                               sync_ref_clock_out_b,
  output logic                               interleave_active,
  output logic                               selftrim_running
);
  import cmc_pkg::*;

  localparam int DLY_TAPS = 1 << SYNC_DLY_W;

  // ==========================================================================
  // Declarations
  logic                    aw_held_ff;
  logic [IDX_W-1:0]        aw_idx_ff;
  logic                    w_held_ff;
  logic [DATA_W-1:0]       w_data_ff;
  logic [DATA_W/8-1:0]     w_strb_ff;
  logic                    bvalid_ff;
  logic [1:0]              bresp_ff;
  logic                    rvalid_ff;
  logic [DATA_W-1:0]       rdata_ff;
  logic [1:0]              rresp_ff;
  logic                    do_write;
  logic [IDX_W-1:0]        ar_idx;
  logic                    wr_hit;
  logic                    rd_hit;
  logic [REG_W-1:0]        mode_reg_ff;
  logic [REG_W-1:0]        sync_reg_ff;
  logic [REG_W-1:0]        nxt_mode_reg;
  logic [REG_W-1:0]        nxt_sync_reg;
  logic [REG_W-1:0]        status_word;
  logic                    ext_mode;
  logic                    interleave_ff;
  logic [DLY_TAPS-1:0]     ref_line_ff;
  logic                    ref_tap;
  logic                    ref_tap_prev_ff;
  logic                    align_pulse;
  logic [SYNC_DLY_W-1:0]   ref_delay;
  logic                    trim_request;
  logic                    trim_running;
  logic                    trim_waiting;

  // ==========================================================================
  // Mode selection
  assign ext_mode = ~serial_control_enable_n;

  // ==========================================================================
  // Register index decode; status takes writes but ignores them
  always_comb
  begin
    wr_hit = 1'b0;
    if (aw_idx_ff == IDX_MODE)
      wr_hit = 1'b1;
    else if (aw_idx_ff == IDX_SYNC)
      wr_hit = 1'b1;
    else if (aw_idx_ff == IDX_STATUS)
      wr_hit = 1'b1;
  end

  // Unmapped reads answer zero with an error code
  always_comb
  begin
    rd_hit = 1'b0;
    if (ar_idx == IDX_MODE)
      rd_hit = 1'b1;
    else if (ar_idx == IDX_SYNC)
      rd_hit = 1'b1;
    else if (ar_idx == IDX_STATUS)
      rd_hit = 1'b1;
  end

  // ==========================================================================
  // AXI4-Lite write channel: address and data taken in either order
  assign s_axi_awready = ~aw_held_ff;
  assign s_axi_wready  = ~w_held_ff;
  assign do_write      = aw_held_ff & w_held_ff & ~bvalid_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_ff <= 1'b0;
      aw_idx_ff  <= '0;
    end
    else if (s_axi_awvalid && !aw_held_ff)
    begin
      aw_held_ff <= 1'b1;
      aw_idx_ff  <= s_axi_awaddr[ADDR_W-1:2];
    end
    else if (do_write)
      aw_held_ff <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_ff <= 1'b0;
      w_data_ff <= '0;
      w_strb_ff <= '0;
    end
    else if (s_axi_wvalid && !w_held_ff)
    begin
      w_held_ff <= 1'b1;
      w_data_ff <= s_axi_wdata;
      w_strb_ff <= s_axi_wstrb;
    end
    else if (do_write)
      w_held_ff <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_ff <= 1'b1;
      if (wr_hit)
        bresp_ff <= RESP_OKAY;
      else
        bresp_ff <= RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_ff <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // ==========================================================================
  // Register next values; byte lanes 0 and 1 carry the 16-bit registers
  always_comb
  begin
    nxt_mode_reg = mode_reg_ff;
    nxt_sync_reg = sync_reg_ff;
    if (do_write && aw_idx_ff == IDX_MODE)
    begin
      if (w_strb_ff[0])
        nxt_mode_reg[7:0] = w_data_ff[7:0];
      if (w_strb_ff[1])
        nxt_mode_reg[15:8] = w_data_ff[15:8];
    end
    else if (do_write && aw_idx_ff == IDX_SYNC)
    begin
      if (w_strb_ff[0])
        nxt_sync_reg[7:0] = w_data_ff[7:0];
      if (w_strb_ff[1])
        nxt_sync_reg[15:8] = w_data_ff[15:8];
    end
  end

  // Registers sit at defaults whenever serial control is off
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !ext_mode)
    begin
      mode_reg_ff <= MODE_RESET;
      sync_reg_ff <= SYNC_RESET;
    end
    else
    begin
      mode_reg_ff <= nxt_mode_reg;
      sync_reg_ff <= nxt_sync_reg;
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  assign s_axi_arready = ~rvalid_ff;
  assign ar_idx        = s_axi_araddr[ADDR_W-1:2];

  always_comb
  begin
    status_word                = '0;
    status_word[STAT_RUN_BIT]  = trim_running;
    status_word[STAT_ILV_BIT]  = interleave_ff;
    status_word[STAT_ECM_BIT]  = ext_mode;
    status_word[STAT_WAIT_BIT] = trim_waiting;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_ff)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      if (ar_idx == IDX_MODE)
        rdata_ff <= {{(DATA_W-REG_W){1'b0}}, mode_reg_ff};
      else if (ar_idx == IDX_SYNC)
        rdata_ff <= {{(DATA_W-REG_W){1'b0}}, sync_reg_ff};
      else if (ar_idx == IDX_STATUS)
        rdata_ff <= {{(DATA_W-REG_W){1'b0}}, status_word};
      else
        rdata_ff <= '0;
    end
    else if (s_axi_rready)
      rvalid_ff <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

  // ==========================================================================
  // Interleaved sampling select
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      interleave_ff <= 1'b0;
    else if (ext_mode)
      interleave_ff <= mode_reg_ff[MODE_ILV_BIT];
    else
      interleave_ff <= interleave_select;
  end

  assign interleave_active = interleave_ff;

  // ==========================================================================
  // Reference input delay line; tap zero is one clock of delay
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ref_line_ff <= '0;
    else
      ref_line_ff <= {ref_line_ff[DLY_TAPS-2:0], ref_clk_in};
  end

  // Delay only adjustable in extended mode; pins give no tap choice
  assign ref_delay = ext_mode ? sync_reg_ff[SYNC_DLY_LSB +: SYNC_DLY_W]
                              : '0;
  assign ref_tap   = ref_line_ff[ref_delay];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ref_tap_prev_ff <= 1'b0;
    else
      ref_tap_prev_ff <= ref_tap;
  end

  // With sync_enable and sync_slave high, a rising edge of the delayed reference resets the divider phase
  assign align_pulse = sync_enable & sync_slave & ref_tap & ~ref_tap_prev_ff;

  cmc_ref_divider u_divider
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .align   (align_pulse),
    .enable  (sync_reg_ff[SYNC_OUT_EN_BIT]),
    .out_a   (sync_ref_clock_out_a),
    .out_b   (sync_ref_clock_out_b)
  );

  // ==========================================================================
  // Self-trim request and sequencer
  assign trim_request = selftrim_request | (ext_mode & mode_reg_ff[MODE_CAL_BIT]);

  cmc_selftrim_seq
  #(
    .WAIT_LONG_CYC  (WAIT_LONG_CYC),
    .WAIT_SHORT_CYC (WAIT_SHORT_CYC),
    .RUN_CYC        (RUN_CYC)
  )
  u_selftrim
  (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .wait_select (power_on_trim_wait_select),
    .request     (trim_request),
    .running     (trim_running),
    .waiting     (trim_waiting)
  );

  assign selftrim_running = trim_running;

  // Protection bits carry no meaning for this slave
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot, w_data_ff[DATA_W-1:REG_W],
                         w_strb_ff[DATA_W/8-1:2]};

endmodule : cmc_control_top

//--- src/cmc_pkg.sv
// Shared constants for the converter mode, self-trim and sync control block.
// Assumes a single 20 MHz clock; no interrupts; AXI4-Lite register access.
package cmc_pkg;

  // ==========================================================================
  // Bus and register map
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam int          REG_W           = 16;
  localparam int          IDX_W           = 6;
  localparam logic [5:0]  IDX_MODE        = 6'h00;
  localparam logic [5:0]  IDX_SYNC        = 6'h0e;
  localparam logic [5:0]  IDX_STATUS      = 6'h10;
  localparam logic [15:0] MODE_RESET      = 16'h0000;
  localparam logic [15:0] SYNC_RESET      = 16'h0000;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // ==========================================================================
  // Field positions
  localparam int          MODE_CAL_BIT    = 15;
  localparam int          MODE_ILV_BIT    = 7;
  localparam int          SYNC_OUT_EN_BIT = 1;
  localparam int          SYNC_DLY_LSB    = 8;
  localparam int          SYNC_DLY_W      = 4;
  localparam int          STAT_RUN_BIT    = 0;
  localparam int          STAT_ILV_BIT    = 1;
  localparam int          STAT_ECM_BIT    = 2;
  localparam int          STAT_WAIT_BIT   = 3;

  // ==========================================================================
  // Timing
  localparam int          CLK_PERIOD_NS   = 50;
  localparam int          WAIT_LONG_US    = 1000;
  localparam int          WAIT_SHORT_US   = 100;
  localparam int          CAL_RUN_US      = 50;
  localparam int          CNT_W           = 32;

  function automatic int us_to_cycles(input int us);
    us_to_cycles = (us * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction : us_to_cycles

  // ==========================================================================
  // Self-trim sequencer states
  typedef enum logic [3:0]
  {
    ST_POR   = 4'b0001,
    ST_WAIT  = 4'b0010,
    ST_READY = 4'b0100,
    ST_RUN   = 4'b1000
  } cmc_cal_state_type;

endpackage : cmc_pkg

//--- src/cmc_ref_divider.sv
// Divide-by-four reference clock generator with phase alignment.
// Assumes align is a one-cycle pulse on aclk.
`timescale 1ns/10ps
module cmc_ref_divider
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic align,
  input  wire logic enable,
  output logic      out_a,
  output logic      out_b
);
  import cmc_pkg::*;

  logic [1:0] phase_ff;
  logic       out_a_ff;
  logic       out_b_ff;

  // ==========================================================================
  // Phase counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      phase_ff <= 2'h0;
    else if (align)
      phase_ff <= 2'h0;
    else
      phase_ff <= phase_ff + 2'h1;
  end

  // ==========================================================================
  // Outputs, held low while disabled
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_a_ff <= 1'b0;
      out_b_ff <= 1'b0;
    end
    else
    begin
      out_a_ff <= enable & phase_ff[1];
      out_b_ff <= enable & phase_ff[1];
    end
  end

  assign out_a = out_a_ff;
  assign out_b = out_b_ff;

endmodule : cmc_ref_divider

//--- src/cmc_selftrim_seq.sv
// Power-on wait and on-command self-trim sequencer.
// Assumes request is the already-combined pin and register request level.
`timescale 1ns/10ps
module cmc_selftrim_seq
#(
  parameter int WAIT_LONG_CYC  = 20000,
  parameter int WAIT_SHORT_CYC = 2000,
  parameter int RUN_CYC        = 1000
)
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic wait_select,
  input  wire logic request,
  output logic      running,
  output logic      waiting
);
  import cmc_pkg::*;

  cmc_cal_state_type    state_ff;
  logic [CNT_W-1:0]     cnt_ff;
  logic                 armed_ff;

  // ==========================================================================
  // Sequencer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff <= ST_POR;
      cnt_ff   <= '0;
    end
    else
    begin
      case (state_ff)
        ST_POR:
        begin
          if (request)
            state_ff <= ST_READY;
          else
          begin
            state_ff <= ST_WAIT;
            cnt_ff   <= wait_select ? CNT_W'(WAIT_LONG_CYC - 1)
                                    : CNT_W'(WAIT_SHORT_CYC - 1);
          end
        end
        ST_WAIT:
        begin
          if (cnt_ff == '0)
          begin
            state_ff <= ST_RUN;
            cnt_ff   <= CNT_W'(RUN_CYC - 1);
          end
          else
            cnt_ff <= cnt_ff - 1'b1;
        end
        ST_READY:
        begin
          if (armed_ff && request)
          begin
            state_ff <= ST_RUN;
            cnt_ff   <= CNT_W'(RUN_CYC - 1);
          end
        end
        ST_RUN:
        begin
          // Requests are not looked at here, so a run is never restarted
          if (cnt_ff == '0)
            state_ff <= ST_READY;
          else
            cnt_ff <= cnt_ff - 1'b1;
        end
        default:
          state_ff <= ST_POR;
      endcase
    end
  end

  // ==========================================================================
  // Low level must be seen while ready before a high counts
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      armed_ff <= 1'b0;
    else if (state_ff != ST_READY)
      armed_ff <= 1'b0;
    else if (!request)
      armed_ff <= 1'b1;
  end

  assign running = (state_ff == ST_RUN);
  assign waiting = (state_ff == ST_WAIT);

endmodule : cmc_selftrim_seq

//--- tb/cmc_control_asserts.sv
// Checker for reference outputs, interleave, trim run and bus holds.
// Assumes it is bound onto cmc_control_top with matching port names.
`timescale 1ns/10ps
module cmc_control_asserts
#(
  parameter int RUN_CYC = 8
)
(
  input wire logic                        aclk,
  input wire logic                        aresetn,
  input wire logic                        s_axi_arvalid,
  input wire logic                        s_axi_arready,
  input wire logic                        s_axi_rvalid,
  input wire logic                        s_axi_rready,
  input wire logic [cmc_pkg::DATA_W-1:0]  s_axi_rdata,
  input wire logic                        s_axi_bvalid,
  input wire logic                        s_axi_bready,
  input wire logic [1:0]                  s_axi_bresp,
  input wire logic                        serial_control_enable_n,
  input wire logic                        interleave_select,
  input wire logic                        sync_enable,
  input wire logic                        sync_ref_clock_out_a,
  input wire logic                        sync_ref_clock_out_b,
  input wire logic                        interleave_active,
  input wire logic                        selftrim_running
);
  import cmc_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ==========================================================================
  // Run length counter
  logic [15:0] run_cnt_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !selftrim_running)
      run_cnt_ff <= 16'h0000;
    else
      run_cnt_ff <= run_cnt_ff + 16'h0001;
  end

  // ==========================================================================
  // Assertions
  ref_high_time_a: assert property (
    $rose(sync_ref_clock_out_a) && !sync_enable && !$past(serial_control_enable_n)
    |=> sync_ref_clock_out_a ##1 !sync_ref_clock_out_a) else $error("ref out high time wrong");
  ref_pair_equal_a: assert property (
    sync_ref_clock_out_a == sync_ref_clock_out_b) else $error("ref outputs differ");
  ref_off_default_a: assert property (
    $past(serial_control_enable_n, 2) |-> !sync_ref_clock_out_a)
    else $error("ref out running with defaults");
  ilv_pin_follow_a: assert property (
    $past(aresetn) && $past(serial_control_enable_n)
    |-> interleave_active == $past(interleave_select)) else $error("interleave not from pin");
  run_length_a: assert property (
    $fell(selftrim_running) |-> run_cnt_ff == 16'(RUN_CYC)) else $error("trim run length wrong");
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  read_latency_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
endmodule : cmc_control_asserts

bind cmc_control_top cmc_control_asserts #(.RUN_CYC(RUN_CYC)) u_chk (.*);

//--- tb/cmc_control_top_tb.sv
// Self-checking bench for the control block with a reference neighbour.
// Assumes short wait and run counts; registers reached over AXI4-Lite.
`timescale 1ns/10ps
module cmc_control_top_tb;
  import cmc_pkg::*;
  localparam int WL = 20;
  localparam int WS = 5;
  localparam int RC = 8;
  localparam int LIMIT = 6000;

  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, serial_control_enable_n, interleave_select, selftrim_request;
  logic        power_on_trim_wait_select, sync_enable, sync_slave, ref_clk_in, ref_run;
  logic        ref_slip, sync_ref_clock_out_a, sync_ref_clock_out_b, interleave_active;
  logic        selftrim_running;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  int          errors, tests_run, cycles;

  cmc_control_top #(.WAIT_LONG_CYC(WL), .WAIT_SHORT_CYC(WS), .RUN_CYC(RC)) DUT (.*);
  cmc_ref_neighbour u_nb (.aclk(aclk), .run(ref_run), .slip(ref_slip), .ref_clk(ref_clk_in));

  always #25 aclk = ~aclk;

  // ==========================================================================
  // Shared tasks
  task automatic results;
    if (errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Leading edge keeps a lowered ready from being raised in the same step
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic do_reset(input logic ws, input logic rq);
    aresetn <= 1'b0;
    power_on_trim_wait_select <= ws;
    selftrim_request <= rq;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  task automatic wait_rise(output int n);
    n = 0;
    while (!selftrim_running)
    begin
      @(posedge aclk);
      n++;
    end
  endtask : wait_rise

  task automatic run_len(output int m);
    m = 0;
    while (selftrim_running)
    begin
      @(posedge aclk);
      m++;
    end
  endtask : run_len

  task automatic idle_run(input int c);
    logic seen;
    seen = 1'b0;
    repeat (c)
    begin
      @(posedge aclk);
      seen = seen | selftrim_running;
    end
    chk("trim idle", 0, seen);
  endtask : idle_run

  task automatic rises(input int c, input int exp);
    int   na;
    logic pa;
    na = 0;
    @(posedge aclk);
    pa = sync_ref_clock_out_a;
    repeat (c)
    begin
      @(posedge aclk);
      if (sync_ref_clock_out_a && !pa) na++;
      pa = sync_ref_clock_out_a;
    end
    chk("ref rises", exp, na);
  endtask : rises

  task automatic ref_phase(output logic v);
    repeat (12) @(posedge aclk);
    @(posedge ref_clk_in);
    @(posedge aclk);
    v = sync_ref_clock_out_a;
  endtask : ref_phase

  // ==========================================================================
  // Scenarios
  task automatic s_power_on(input logic ws, input int lo);
    int n;
    int m;
    do_reset(ws, 1'b0);
    wait_rise(n);
    chk("trim wait", 1, n >= lo && n <= lo + 4);
    run_len(m);
    chk("trim length", RC, m);
  endtask : s_power_on

  task automatic s_inhibit;
    int n;
    int m;
    do_reset(1'b0, 1'b1);
    idle_run(40);
    selftrim_request <= 1'b0;
    repeat (3) @(posedge aclk);
    selftrim_request <= 1'b1;
    wait_rise(n);
    chk("cmd start", 1, n <= 3);
    repeat (2) @(posedge aclk);
    selftrim_request <= 1'b0;
    repeat (2) @(posedge aclk);
    selftrim_request <= 1'b1;
    run_len(m);
    chk("busy length", RC - 4, m);
    idle_run(12);
  endtask : s_inhibit

  task automatic s_ecm_request;
    int n;
    serial_control_enable_n <= 1'b0;
    axi_wr(8'h00, 32'h0);
    selftrim_request <= 1'b0;
    repeat (3) @(posedge aclk);
    axi_wr(8'h00, 32'h8000);
    chk("bresp", RESP_OKAY, rs);
    wait_rise(n);
    chk("bit start", 1, n <= 3);
    axi_rd(8'h40);
    chk("status word", (1 << STAT_RUN_BIT) | (1 << STAT_ECM_BIT), rd);
    run_len(n);
    idle_run(12);
  endtask : s_ecm_request

  task automatic s_interleave;
    serial_control_enable_n <= 1'b1;
    interleave_select <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("ilv pin high", 1, interleave_active);
    interleave_select <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("ilv pin low", 0, interleave_active);
    serial_control_enable_n <= 1'b0;
    interleave_select <= 1'b1;
    axi_wr(8'h00, 32'h0);
    repeat (3) @(posedge aclk);
    chk("ilv pin ignored", 0, interleave_active);
    axi_wr(8'h00, 32'h80);
    repeat (3) @(posedge aclk);
    chk("ilv bit", 1, interleave_active);
    serial_control_enable_n <= 1'b1;
    interleave_select <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("ilv back to pin", 0, interleave_active);
    axi_rd(8'h00);
    chk("mode default", MODE_RESET, rd);
  endtask : s_interleave

  task automatic s_refout;
    logic v0;
    logic v1;
    serial_control_enable_n <= 1'b0;
    axi_rd(8'h38);
    chk("sync default", SYNC_RESET, rd);
    rises(20, 0);
    axi_wr(8'h38, 32'h2);
    rises(40, 10);
    sync_enable <= 1'b1;
    sync_slave <= 1'b1;
    ref_run <= 1'b1;
    ref_phase(v0);
    ref_slip <= 1'b1;
    @(posedge aclk);
    ref_slip <= 1'b0;
    ref_phase(v1);
    chk("aligned phase", v0, v1);
    axi_wr(8'h38, 32'h202);
    ref_phase(v1);
    chk("delayed phase", !v0, v1);
    axi_rd(8'h04);
    chk("unmapped resp", RESP_SLVERR, rs);
    axi_wr(8'h04, 32'h2);
    chk("unmapped wr", RESP_SLVERR, rs);
    serial_control_enable_n <= 1'b1;
    repeat (3) @(posedge aclk);
    rises(20, 0);
  endtask : s_refout

  // ==========================================================================
  // Watchdog and main sequence
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      errors++;
      results();
    end
  end

  initial
  begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
    {s_axi_arvalid, s_axi_rready, interleave_select, selftrim_request} = 4'h0;
    {power_on_trim_wait_select, sync_enable, sync_slave, ref_run, ref_slip} = 5'h00;
    serial_control_enable_n = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_awprot, s_axi_arprot} = 6'h00;
    s_axi_wstrb = 4'hf;
    s_power_on(1'b1, WL);
    s_power_on(1'b0, WS);
    s_inhibit();
    s_ecm_request();
    s_interleave();
    s_refout();
    results();
  end
endmodule : cmc_control_top_tb

//--- tb/cmc_ref_neighbour.sv
// Model of a neighbouring converter driving the reference clock input.
// Assumes one clock; run starts the clock, slip stalls its phase one cycle.
`timescale 1ns/10ps
module cmc_ref_neighbour
(
  input  wire logic aclk,
  input  wire logic run,
  input  wire logic slip,
  output logic      ref_clk
);
  // ==========================================================================
  // Divide-by-four source
  logic [1:0] ph_ff;
  logic       ref_ff;

  always_ff @(posedge aclk)
  begin
    if (!run)
      ph_ff <= 2'h0;
    else if (!slip)
      ph_ff <= ph_ff + 2'h1;
  end

  // Stands low between runs, like a neighbour with outputs disabled
  always_ff @(posedge aclk)
  begin
    ref_ff <= run & ph_ff[1];
  end

  assign ref_clk = ref_ff;
endmodule : cmc_ref_neighbour
